// >>> dv/dcesf_flags_props.sv
// Port checks for the disk controller error status flag block
`timescale 1ns/100ps
`default_nettype none
module dcesf_props
  import dcesf_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [1:0] addr,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       cmd_start,
  input wire logic       cmd_done,
  input wire logic       in_result,
  input wire logic [1:0] term_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Read port and result phase relations
  chk_idle_zero: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("rdata not zero without read");
  chk_unmapped_zero: assert property (rd_stb && addr == 2'h3 |=>
    rdata == 8'h00) else $error("unmapped read not zero");
  chk_one_unused: assert property (rd_stb && addr == 2'h0 |=>
    !rdata[3] && !rdata[6]) else $error("unused bit set in byte one");
  chk_two_unused: assert property (rd_stb && addr == 2'h1 |=>
    !rdata[7]) else $error("unused bit set in byte two");
  chk_term_field: assert property (rd_stb && addr == 2'h2 |=>
    rdata == {$past(term_code), 6'h00}) else $error("term read wrong");
  chk_term_legal: assert property (term_code[1] == 1'b0)
    else $error("illegal termination code");
  chk_done_result: assert property (cmd_done && !cmd_start |=>
    in_result) else $error("no result phase after done");
  chk_start_exec: assert property (cmd_start |=> !in_result)
    else $error("result phase kept after start");
  chk_result_hold: assert property (in_result && !cmd_start |=>
    in_result && $stable(term_code)) else $error("result not held");
endmodule : dcesf_props
bind dcesf_flags dcesf_props u_props (.clock(clock), .rst_n(rst_n),
  .addr(addr), .rd_stb(rd_stb), .rdata(rdata), .cmd_start(cmd_start),
  .cmd_done(cmd_done), .in_result(in_result), .term_code(term_code));
`default_nettype wire

// >>> dv/dcesf_host.sv
// Host model that strobes the register port and takes read data
`timescale 1ns/100ps
`default_nettype none
module dcesf_host (
  input  wire logic       clock,
  input  wire logic       req,
  input  wire logic       wreq,
  input  wire logic [1:0] req_addr,
  input  wire logic [7:0] rdata,
  output logic      [1:0] addr,
  output logic            rd_stb,
  output logic            wr_stb,
  output logic      [7:0] got
);
  logic rd_d_reg = 1'b0;
  initial {addr, rd_stb, wr_stb} = 4'h0;
  // One strobe a cycle; data taken in the cycle after a read strobe
  always @(posedge clock) begin
    rd_stb <= req;
    wr_stb <= wreq;
    addr <= req_addr;
    rd_d_reg <= rd_stb;
    if (rd_d_reg) got <= rdata;
  end
endmodule : dcesf_host
`default_nettype wire

// >>> dv/tb.sv
// Bench for the disk controller error status flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import dcesf_pkg::*;
  logic clock = 0, rst_n = 0, cmd_start = 0, cmd_done = 0, req = 0, wreq = 0;
  logic index_pin = 0, wprot_pin = 0, rd_stb, wr_stb, in_result;
  logic [11:0] ev = 0;
  logic [1:0] req_addr = 0, addr, term_code;
  logic [7:0] wdata = 0, rdata, got, cm, cr;
  dcesf_cmd_t cmd_code = DCESF_CMD_OTHER;
  int fail_count = 0, checked = 0, cyc = 0;
  dcesf_flags uut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_done(cmd_done),
    .in_result(in_result), .term_code(term_code), .id_mark_found(ev[11]),
    .data_mark_missing(ev[0]), .sector_missing(ev[1]),
    .id_field_bad(ev[2]), .xfer_overrun(ev[3]), .id_crc_err(ev[4]),
    .data_crc_err(ev[5]), .past_cyl_end(ev[6]), .cyl_check(ev[7]),
    .cyl_on_medium(cm), .cyl_requested(cr), .scan_no_match(ev[8]),
    .scan_equal(ev[9]), .deleted_mark(ev[10]), .index_pin(index_pin),
    .wprot_pin(wprot_pin));
  dcesf_host host (.clock(clock), .req(req), .wreq(wreq),
    .req_addr(req_addr), .rdata(rdata), .addr(addr), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .got(got));
  // Clock and hang guard
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run;
    end
  end
  // Register read through the host, compared with the expectation
  task automatic rd(logic [1:0] a, logic [7:0] e);
    req <= 1;
    req_addr <= a;
    @(posedge clock);
    req <= 0;
    repeat (3) @(posedge clock);
    `CHK("rdata", e, got)
  endtask : rd
  // One command: events, optional index holes and write protect, result
  task automatic run(dcesf_cmd_t c, logic [13:0] v, logic [7:0] a, b);
    logic [7:0] t;
    t = ((a | (b & 8'hF7)) != 8'h00) ? 8'h40 : 8'h00;
    @(posedge clock);
    cmd_start <= 1;
    cmd_code <= c;
    @(posedge clock);
    cmd_start <= 0;
    ev <= v[11:0];
    wprot_pin <= v[12];
    @(posedge clock);
    ev <= 0;
    repeat (2) begin
      index_pin <= v[13];
      repeat (4) @(posedge clock);
      index_pin <= 0;
      repeat (4) @(posedge clock);
    end
    wprot_pin <= 0;
    cmd_done <= 1;
    @(posedge clock);
    cmd_done <= 0;
    wreq <= 1;
    wdata <= 8'($urandom);
    @(posedge clock);
    wreq <= 0;
    `CHK("in_result", 1'b1, in_result)
    rd(2'h0, a);
    rd(2'h1, b);
    rd(2'h2, t);
    rd(2'h3, 8'h00);
    `CHK("term_code", t[7:6], term_code)
  endtask : run
  task automatic complete_run;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    cr = 8'($urandom(10010) % 127);
    cm = cr;
    repeat (10) @(posedge clock);
    rst_n <= 1;
    `CHK("reset in_result", 1'b0, in_result)
    `CHK("reset term_code", 2'h0, term_code)
    run(DCESF_CMD_READ_DATA, 14'h0001, 8'h01, 8'h01);
    run(DCESF_CMD_READ_DATA, 14'h0002, 8'h04, 8'h00);
    run(DCESF_CMD_WRITE_DELETED, 14'h0002, 8'h04, 8'h00);
    run(DCESF_CMD_SCAN, 14'h0002, 8'h04, 8'h00);
    run(DCESF_CMD_ID_FETCH, 14'h0004, 8'h04, 8'h00);
    run(DCESF_CMD_READ_TRACK, 14'h0002, 8'h04, 8'h00);
    run(DCESF_CMD_READ_DATA, 14'h0008, 8'h10, 8'h00);
    run(DCESF_CMD_READ_DATA, 14'h0010, 8'h20, 8'h00);
    run(DCESF_CMD_READ_DATA, 14'h0020, 8'h20, 8'h20);
    run(DCESF_CMD_READ_DATA, 14'h0040, 8'h80, 8'h00);
    run(DCESF_CMD_SCAN, 14'h0100, 8'h00, 8'h04);
    run(DCESF_CMD_SCAN, 14'h0200, 8'h00, 8'h08);
    run(DCESF_CMD_READ_DATA, 14'h0400, 8'h00, 8'h40);
    run(DCESF_CMD_WRITE_DATA, 14'h1000, 8'h02, 8'h00);
    run(DCESF_CMD_FORMAT_TRACK, 14'h1000, 8'h02, 8'h00);
    run(DCESF_CMD_READ_DATA, 14'h1000, 8'h00, 8'h00);
    run(DCESF_CMD_READ_DATA, 14'h2000, 8'h01, 8'h00);
    run(DCESF_CMD_READ_DATA, 14'h2800, 8'h00, 8'h00);
    cm = 8'hFF;
    run(DCESF_CMD_READ_DATA, 14'h0082, 8'h04, 8'h12);
    cm = cr + 8'h80;
    run(DCESF_CMD_READ_DATA, 14'h0082, 8'h04, 8'h10);
    complete_run;
  end
endmodule : tb
`default_nettype wire

// >>> logic/dcesf_consts.svh
// Constants for the disk controller error status flag block
`ifndef DCESF_CONSTS_SVH
`define DCESF_CONSTS_SVH
`define DCESF_ADDR_W        2
`define DCESF_OFF_ERR_ONE   2'h0
`define DCESF_OFF_ERR_TWO   2'h1
`define DCESF_OFF_TERM      2'h2
`define DCESF_CYL_BLANK     8'hFF
`define DCESF_E1_NO_ID_MARK 0
`define DCESF_E1_WPROT      1
`define DCESF_E1_NO_SECTOR  2
`define DCESF_E1_OVERRUN    4
`define DCESF_E1_CRC        5
`define DCESF_E1_END_CYL    7
`define DCESF_E2_NO_DMARK   0
`define DCESF_E2_BAD_CYL    1
`define DCESF_E2_SCAN_MISS  2
`define DCESF_E2_SCAN_EQ    3
`define DCESF_E2_WRONG_CYL  4
`define DCESF_E2_DATA_CRC   5
`define DCESF_E2_DELETED    6
`define DCESF_USED_ONE      8'hB7
`define DCESF_USED_TWO      8'h7F
`define DCESF_TERM_ABNORMAL 2'h1
`define DCESF_TERM_NORMAL   2'h0
`endif

// >>> logic/dcesf_flags.sv
// Error status flags of a flexible disk controller, with register port
`include "dcesf_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dcesf_flags
  import dcesf_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Register port
  input  wire logic [`DCESF_ADDR_W-1:0] addr,
  input  wire logic                     wr_stb,
  input  wire logic                     rd_stb,
  input  wire logic [7:0]               wdata,
  output logic      [7:0]               rdata,
  // Command sequencing from the controller core
  input  wire logic                     cmd_start,
  input  wire dcesf_cmd_t               cmd_code,
  input  wire logic                     cmd_done,
  output logic                          in_result,
  output logic      [1:0]               term_code,
  // Events from the drive side, one cycle pulses on this clock, except the two cylinder bytes
  input  wire logic                     id_mark_found,
  input  wire logic                     data_mark_missing,
  input  wire logic                     sector_missing,
  input  wire logic                     id_field_bad,
  input  wire logic                     xfer_overrun,
  input  wire logic                     id_crc_err,
  input  wire logic                     data_crc_err,
  input  wire logic                     past_cyl_end,
  input  wire logic                     cyl_check,
  input  wire logic [7:0]               cyl_on_medium,
  input  wire logic [7:0]               cyl_requested,
  input  wire logic                     scan_no_match,
  input  wire logic                     scan_equal,
  input  wire logic                     deleted_mark,
  // Drive pins, asynchronous to this clock
  input  wire logic                     index_pin,
  input  wire logic                     wprot_pin
);

  dcesf_state_t st_reg;
  dcesf_state_t st_next;

  // True while the command is one of the listed kinds
  function automatic logic cmd_is(input dcesf_cmd_t c, input dcesf_cmd_t a,
                                  input dcesf_cmd_t b, input dcesf_cmd_t d);
    cmd_is = (c == a) || (c == b) || (c == d);
  endfunction : cmd_is

  logic        exec;
  logic        index_rise;
  logic        not_found;
  logic [7:0]  set_one;
  logic [7:0]  set_two;
  logic        any_err;

  assign exec       = (st_reg.phase == DCESF_EXEC);
  assign index_rise = st_reg.index_s2 & ~st_reg.index_d;

  // Flag set terms gathered per bit
  always_comb begin
    set_one = 8'h00;
    set_two = 8'h00;
    not_found = 1'b0;
    if (exec) begin
      if (index_rise && !st_reg.id_seen && st_reg.index_cnt == 2'h1) begin
        set_one[`DCESF_E1_NO_ID_MARK] = 1'b1;
      end
      if (data_mark_missing) begin
        set_one[`DCESF_E1_NO_ID_MARK] = 1'b1;
        set_two[`DCESF_E2_NO_DMARK]   = 1'b1;
      end
      if (st_reg.wprot_s2 && cmd_is(st_reg.cmd, DCESF_CMD_WRITE_DATA,
          DCESF_CMD_WRITE_DELETED, DCESF_CMD_FORMAT_TRACK)) begin
        set_one[`DCESF_E1_WPROT] = 1'b1;
      end
      if (sector_missing && cmd_is(st_reg.cmd, DCESF_CMD_READ_DATA,
          DCESF_CMD_WRITE_DELETED, DCESF_CMD_SCAN)) begin
        not_found = 1'b1;
      end
      if (id_field_bad && st_reg.cmd == DCESF_CMD_ID_FETCH) begin
        not_found = 1'b1;
      end
      if (sector_missing && st_reg.cmd == DCESF_CMD_READ_TRACK) begin
        not_found = 1'b1;
      end
      set_one[`DCESF_E1_NO_SECTOR] = not_found;
      if (xfer_overrun) begin
        set_one[`DCESF_E1_OVERRUN] = 1'b1;
      end
      if (id_crc_err || data_crc_err) begin
        set_one[`DCESF_E1_CRC] = 1'b1;
      end
      if (past_cyl_end) begin
        set_one[`DCESF_E1_END_CYL] = 1'b1;
      end
      if (not_found && cyl_check && cyl_on_medium != cyl_requested) begin
        set_two[`DCESF_E2_WRONG_CYL] = 1'b1;
        if (cyl_on_medium == `DCESF_CYL_BLANK) begin
          set_two[`DCESF_E2_BAD_CYL] = 1'b1;
        end
      end
      if (st_reg.cmd == DCESF_CMD_SCAN) begin
        set_two[`DCESF_E2_SCAN_MISS] = scan_no_match;
        set_two[`DCESF_E2_SCAN_EQ]   = scan_equal;
      end
      if (data_crc_err) begin
        set_two[`DCESF_E2_DATA_CRC] = 1'b1;
      end
      if (deleted_mark && (st_reg.cmd == DCESF_CMD_READ_DATA ||
          st_reg.cmd == DCESF_CMD_SCAN)) begin
        set_two[`DCESF_E2_DELETED] = 1'b1;
      end
    end
  end

  assign any_err = |(st_reg.err_one | set_one) |
                   |((st_reg.err_two | set_two) &
                     ~(8'h01 << `DCESF_E2_SCAN_EQ));

  // Next state of the whole block
  always_comb begin
    st_next          = st_reg;
    st_next.wprot_s1 = wprot_pin;
    st_next.wprot_s2 = st_reg.wprot_s1;
    st_next.index_s1 = index_pin;
    st_next.index_s2 = st_reg.index_s1;
    st_next.index_d  = st_reg.index_s2;
    st_next.rdata    = 8'h00;
    if (cmd_start) begin
      st_next.phase     = DCESF_EXEC;
      st_next.cmd       = cmd_code;
      st_next.err_one   = 8'h00;
      st_next.err_two   = 8'h00;
      st_next.term      = `DCESF_TERM_NORMAL;
      st_next.index_cnt = 2'h0;
      st_next.id_seen   = 1'b0;
    end else if (exec) begin
      st_next.err_one = (st_reg.err_one | set_one) & `DCESF_USED_ONE;
      st_next.err_two = (st_reg.err_two | set_two) & `DCESF_USED_TWO;
      if (id_mark_found) begin
        st_next.id_seen = 1'b1;
      end
      if (index_rise && st_reg.index_cnt != 2'h2) begin
        st_next.index_cnt = st_reg.index_cnt + 2'h1;
      end
      if (cmd_done) begin
        st_next.phase = DCESF_RESULT;
        st_next.term  = any_err ? `DCESF_TERM_ABNORMAL
                                : `DCESF_TERM_NORMAL;
      end
    end
    // Read data one cycle after the strobe; writes have no effect
    if (rd_stb) begin
      unique case (addr)
        `DCESF_OFF_ERR_ONE: st_next.rdata = st_reg.err_one;
        `DCESF_OFF_ERR_TWO: st_next.rdata = st_reg.err_two;
        `DCESF_OFF_TERM:    st_next.rdata = {st_reg.term, 6'h00};
        default:            st_next.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{phase: DCESF_IDLE, cmd: DCESF_CMD_OTHER, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata     = st_reg.rdata;
  assign in_result = (st_reg.phase == DCESF_RESULT);
  assign term_code = st_reg.term;

endmodule : dcesf_flags
`default_nettype wire

// >>> logic/dcesf_pkg.sv
// Types for the disk controller error status flag block
package dcesf_pkg;
  typedef enum logic [2:0] {
    DCESF_CMD_READ_DATA,
    DCESF_CMD_WRITE_DATA,
    DCESF_CMD_WRITE_DELETED,
    DCESF_CMD_FORMAT_TRACK,
    DCESF_CMD_SCAN,
    DCESF_CMD_ID_FETCH,
    DCESF_CMD_READ_TRACK,
    DCESF_CMD_OTHER
  } dcesf_cmd_t;

  typedef enum logic [1:0] {
    DCESF_IDLE,
    DCESF_EXEC,
    DCESF_RESULT
  } dcesf_phase_t;

  typedef struct packed {
    dcesf_phase_t phase;
    dcesf_cmd_t   cmd;
    logic [7:0]   err_one;
    logic [7:0]   err_two;
    logic [1:0]   term;
    logic [7:0]   rdata;
    logic [1:0]   index_cnt;
    logic         id_seen;
    logic         wprot_s1;
    logic         wprot_s2;
    logic         index_s1;
    logic         index_s2;
    logic         index_d;
  } dcesf_state_t;
endpackage : dcesf_pkg
